// File: logic/lbal_dev_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "lbal_defines.svh"
module lbal_dev_end (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset, low
  lbal_if.dev bus, // link to memory end
  input wire logic i_req_valid, // request offered
  output logic o_req_ready, // request accepted this clock
  input wire logic i_req_write, // write when high
  input wire logic i_req_fetch, // instruction fetch
  input wire logic i_req_signed, // sign extend 8- and 16-bit reads
  input wire lbal_pkg::lbal_size_t i_req_size, // item size code
  input wire logic [31:0] i_req_addr, // byte address
  input wire logic [127:0] i_req_wdata, // write data, low aligned
  input wire logic i_supervisor, // supervisor mode
  input wire logic i_set_big, // endian set strobe
  input wire logic i_big_value, // new endian mode
  output logic o_big_endian, // current endian mode
  output logic o_trap, // misalign trap pulse
  output logic o_rsp_valid, // read result valid
  input wire logic i_rsp_ready, // result consumer ready
  output logic [63:0] o_rsp_data, // read result word
  output logic [1:0] o_outstanding // transfers in flight
);
  import lbal_pkg::*;
  lbal_state_t state, next_state;
  logic big, next_big, trap, next_trap, ads_n, next_ads_n, wnr, next_wnr;
  logic [28:0] addr, next_addr;
  logic [63:0] wdata, next_wdata, hi_word, next_hi_word;
  logic [7:0] lsel_n, next_lsel_n;
  logic [1:0] outs, next_outs;
  // open cycles, oldest in the low byte: {write, signed, size, lane}
  logic [23:0] flight, next_flight;
  logic [7:0] rec;
  logic [1:0] keep;
  logic [2:0] words;
  logic done_now;
  // derived request view
  logic [3:0] amask;
  logic misalign, use_big, take;
  logic [2:0] lane;
  logic [7:0] lanes;
  logic [63:0] shifted, rd_word, ext;
  // two-entry result buffer
  logic [63:0] buf_d [0:1];
  logic [1:0] buf_n;
  logic buf_wp, buf_rp, push, pop, buf_ready;
  // size-driven alignment check and lane placement
  always_comb begin
    case (i_req_size)
      `LBAL_SZ_16: amask = `LBAL_AMASK_16;
      `LBAL_SZ_32: amask = `LBAL_AMASK_32;
      `LBAL_SZ_64: amask = `LBAL_AMASK_64;
      `LBAL_SZ_128: amask = `LBAL_AMASK_128;
      default: amask = 4'h0;
    endcase
    misalign = |(i_req_addr[3:0] & amask);
    use_big = big && !i_req_fetch;
    case (i_req_size)
      `LBAL_SZ_8: lanes = `LBAL_LANES_ONE;
      `LBAL_SZ_16: lanes = `LBAL_LANES_PAIR;
      `LBAL_SZ_32: lanes = `LBAL_LANES_HALF;
      default: lanes = `LBAL_LANES_ALL;
    endcase
    // big endian mirrors lane index within the word
    case (i_req_size)
      `LBAL_SZ_8: lane = use_big ? `LBAL_LANE_MAX - i_req_addr[2:0] : i_req_addr[2:0];
      `LBAL_SZ_16: lane = use_big ? 3'h6 - {i_req_addr[2:1], 1'b0} : {i_req_addr[2:1], 1'b0};
      `LBAL_SZ_32: lane = use_big ? 3'h4 - {i_req_addr[2], 2'b00} : {i_req_addr[2], 2'b00};
      default: lane = `LBAL_ZERO_BYTE;
    endcase
    lanes = 8'(lanes << lane);
    shifted = 64'(i_req_wdata[63:0] << {lane, 3'b000});
  end
  // pipelined issue limited by outstanding count; buffer room reserved
  // a 128-bit read opens two cycles and fills two slots; open writes hold a slot too,
  // which costs some read overlap but can never overrun the buffer
  assign words = (i_req_size == `LBAL_SZ_128) ? `LBAL_WORDS_TWO : `LBAL_WORDS_ONE;
  assign done_now = !bus.cycle_done_n && outs != 2'h0;
  assign buf_ready = (3'(buf_n) + 3'(outs) + words) <= `LBAL_BUF_DEPTH;
  assign take = i_req_valid && (state == LBAL_IDLE) && (misalign
    || ((3'(outs) + words) <= 3'(`LBAL_MAX_OUT) && (i_req_write || buf_ready)));
  assign o_req_ready = take;
  // read word: shift wanted byte to lane 0, keep size, extend
  always_comb begin
    rd_word = bus.rdata >> {flight[2:0], 3'b000};
    case (flight[5:3])
      `LBAL_SZ_8: ext = {{56{flight[6] & rd_word[7]}}, rd_word[7:0]};
      `LBAL_SZ_16: ext = {{48{flight[6] & rd_word[15]}}, rd_word[15:0]};
      `LBAL_SZ_32: ext = {32'h0, rd_word[31:0]};
      default: ext = bus.rdata;
    endcase
  end
  // issue state, endian mode and outstanding count
  always_comb begin
    next_state = state;
    next_big = big;
    next_trap = 1'b0;
    next_ads_n = 1'b1; // strobe lasts one clock
    next_wnr = wnr;
    next_addr = addr;
    next_wdata = wdata;
    next_hi_word = hi_word;
    next_lsel_n = lsel_n;
    rec = {wnr, 1'b0, `LBAL_SZ_128, `LBAL_ZERO_BYTE}; // second half of a 128-bit item
    next_outs = outs;
    if (i_set_big && i_supervisor) begin
      next_big = i_big_value;
    end
    case (state)
      LBAL_IDLE: begin
        if (take && misalign) begin
          next_trap = 1'b1; // no cycle started
        end else if (take) begin
          next_ads_n = 1'b0;
          next_wnr = i_req_write;
          next_addr = i_req_addr[31:3];
          next_wdata = shifted;
          next_hi_word = i_req_wdata[127:64];
          next_lsel_n = ~lanes; // also on reads
          rec = {i_req_write, i_req_signed, i_req_size, lane};
          if (i_req_size == `LBAL_SZ_128) begin
            next_state = LBAL_SECOND;
          end else begin
            next_state = LBAL_ISSUE;
          end
        end
      end
      LBAL_SECOND: begin
        // second half of a 128-bit item, always one clock later
        next_ads_n = 1'b0;
        next_addr = addr + `LBAL_WORD_STEP;
        next_wdata = hi_word;
        next_state = LBAL_ISSUE;
      end
      LBAL_ISSUE: next_state = LBAL_IDLE; // new cycle every other clock
      default: next_state = LBAL_IDLE;
    endcase
    next_outs = 2'(outs + {1'b0, !next_ads_n} - {1'b0, done_now});
    // answers come in order: retire the oldest, file the new cycle behind the rest
    keep = 2'(outs - {1'b0, done_now});
    next_flight = done_now ? {8'h00, flight[23:8]} : flight;
    if (!next_ads_n) begin
      next_flight[{keep, 3'b000} +: 8] = rec;
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= LBAL_IDLE;
      big <= 1'b0;
      trap <= 1'b0;
      ads_n <= 1'b1;
      wnr <= 1'b0;
      addr <= 29'h0;
      wdata <= 64'h0;
      hi_word <= 64'h0;
      lsel_n <= 8'hff;
      flight <= 24'h0;
      outs <= 2'h0;
    end else begin
      state <= next_state;
      big <= next_big;
      trap <= next_trap;
      ads_n <= next_ads_n;
      wnr <= next_wnr;
      addr <= next_addr;
      wdata <= next_wdata;
      hi_word <= next_hi_word;
      lsel_n <= next_lsel_n;
      flight <= next_flight;
      outs <= next_outs;
    end
  end
  // result buffer; space reserved at issue so a stall loses no word
  assign push = done_now && !flight[7]; // direction of the cycle being answered
  assign pop = o_rsp_valid && i_rsp_ready;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      buf_n <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 64'h0;
    end else begin
      if (push) begin
        buf_d[buf_wp] <= ext;
        buf_wp <= !buf_wp;
      end
      if (pop) begin
        buf_rp <= !buf_rp;
      end
      buf_n <= 2'(buf_n + {1'b0, push} - {1'b0, pop});
      o_rsp_valid <= (2'(buf_n + {1'b0, push} - {1'b0, pop})) != 2'h0;
      o_rsp_data <= (pop || !o_rsp_valid) ? ((buf_n - {1'b0, pop}) != 2'h0 ?
        buf_d[!buf_rp ^ !pop] : ext) : o_rsp_data;
    end
  end
  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign bus.lane_select_n = lsel_n;
  assign bus.cycle_start_strobe_n = ads_n;
  assign bus.write_not_read = wnr;
  assign o_big_endian = big;
  assign o_trap = trap;
  assign o_outstanding = outs;
endmodule
`default_nettype wire

// File: logic/lbal_defines.svh
`ifndef LBAL_DEFINES_SVH
`define LBAL_DEFINES_SVH
// size codes
`define LBAL_SZ_8 3'h0
`define LBAL_SZ_16 3'h1
`define LBAL_SZ_32 3'h2
`define LBAL_SZ_64 3'h3
`define LBAL_SZ_128 3'h4
// alignment masks on the low four address bits
`define LBAL_AMASK_16 4'h1
`define LBAL_AMASK_32 4'h3
`define LBAL_AMASK_64 4'h7
`define LBAL_AMASK_128 4'hf
// lane select patterns, active high before inversion
`define LBAL_LANES_ALL 8'hff
`define LBAL_LANES_HALF 8'h0f
`define LBAL_LANES_PAIR 8'h03
`define LBAL_LANES_ONE 8'h01
`define LBAL_LANES_NONE 8'h00
`define LBAL_LANE_MAX 3'h7
// pipelining depth: at most three outstanding transfers
`define LBAL_MAX_OUT 2'h3
// result buffer slots and bus words per item
`define LBAL_BUF_DEPTH 3'h2
`define LBAL_WORDS_ONE 3'h1
`define LBAL_WORDS_TWO 3'h2
`define LBAL_WORD_STEP 29'h0000001
`define LBAL_ZERO_BYTE 3'h0
`endif

// File: logic/lbal_pkg.sv
package lbal_pkg;
  `include "lbal_defines.svh"
  typedef logic [2:0] lbal_size_t;
  typedef enum logic [1:0] {
    LBAL_IDLE = 2'b00,
    LBAL_ISSUE = 2'b01,
    LBAL_SECOND = 2'b10
  } lbal_state_t;
endpackage

// File: logic/lbal_if.sv
`timescale 1ns/10ps
`default_nettype none
interface lbal_if;
  logic [28:0] addr;
  logic [63:0] wdata;
  logic [63:0] rdata;
  logic [7:0] lane_select_n;
  logic cycle_start_strobe_n;
  logic write_not_read;
  logic cycle_done_n;
  logic next_address_request_n;
  logic cache_fill_enable_n;
  modport dev (output addr, wdata, lane_select_n, cycle_start_strobe_n, write_not_read,
    input rdata, cycle_done_n, next_address_request_n, cache_fill_enable_n);
  modport mem (input addr, wdata, lane_select_n, cycle_start_strobe_n, write_not_read,
    output rdata, cycle_done_n, next_address_request_n, cache_fill_enable_n);
endinterface
`default_nettype wire

// File: logic/lbal_mem_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "lbal_defines.svh"
module lbal_mem_end #(
  parameter int DEPTH_W = 6
) (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset, low
  lbal_if.mem bus, // link to device end
  input wire logic i_io_space, // decoder says this address is i/o
  output logic o_io_hit, // last transfer went to i/o
  output logic o_busy // transfer outstanding
);
  import lbal_pkg::*;
  logic [63:0] mem [0:(1<<DEPTH_W)-1];
  logic [63:0] rdata, next_rdata;
  logic done_n, next_done_n, ken_n, next_ken_n, io_hit, next_io_hit;
  logic busy, next_busy, wr, next_wr;
  logic [28:0] adr, next_adr;
  logic [7:0] lanes, next_lanes;
  logic [63:0] wd, next_wd;
  // capture each strobe, answer one clock later; back-to-back strobes
  // (both halves of a 128-bit item) each get an answer of their own
  always_comb begin
    next_busy = !bus.cycle_start_strobe_n;
    next_done_n = !busy;
    next_rdata = rdata;
    next_ken_n = ken_n;
    next_io_hit = io_hit;
    next_wr = wr;
    next_adr = adr;
    next_lanes = lanes;
    next_wd = wd;
    if (!bus.cycle_start_strobe_n) begin
      next_wr = bus.write_not_read;
      next_adr = bus.addr;
      next_lanes = ~bus.lane_select_n;
      next_wd = bus.wdata;
      next_io_hit = i_io_space;
    end
    if (busy) begin
      next_rdata = mem[adr[DEPTH_W-1:0]]; // all lanes, never gated
      next_ken_n = io_hit; // i/o reads keep caches out
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      busy <= 1'b0;
      done_n <= 1'b1;
      rdata <= 64'h0;
      ken_n <= 1'b1;
      io_hit <= 1'b0;
      wr <= 1'b0;
      adr <= 29'h0;
      lanes <= 8'h0;
      wd <= 64'h0;
    end else begin
      busy <= next_busy;
      done_n <= next_done_n;
      rdata <= next_rdata;
      ken_n <= next_ken_n;
      io_hit <= next_io_hit;
      wr <= next_wr;
      adr <= next_adr;
      lanes <= next_lanes;
      wd <= next_wd;
    end
  end
  // only selected lanes are written
  always_ff @(posedge i_clk) begin
    if (busy && wr) begin
      for (int b = 0; b < 8; b++) begin
        if (lanes[b]) begin
          mem[adr[DEPTH_W-1:0]][b*8 +: 8] <= wd[b*8 +: 8];
        end
      end
    end
  end
  assign bus.rdata = rdata;
  assign bus.cycle_done_n = done_n;
  assign bus.cache_fill_enable_n = ken_n;
  assign bus.next_address_request_n = 1'b1; // no pipelining requested here
  assign o_io_hit = io_hit;
  assign o_busy = busy;
endmodule
`default_nettype wire

// File: bench/lbal_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lbal_checker (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // sync reset, low
  input wire logic [28:0] addr, // word address
  input wire logic [7:0] lane_select_n, // lanes, low
  input wire logic cycle_start_strobe_n, // start, low
  input wire logic write_not_read, // direction
  input wire logic cycle_done_n // done, low
);
  logic [2:0] open_cnt;
  logic [2:0] next_open_cnt;
  // started minus answered; three bits so an overrun shows
  always_comb begin
    next_open_cnt = open_cnt + {2'h0, !cycle_start_strobe_n} - {2'h0, !cycle_done_n};
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) open_cnt <= 3'h0;
    else open_cnt <= next_open_cnt;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    !cycle_start_strobe_n;
  endsequence
  sequence s_pair;
    !cycle_start_strobe_n ##1 !cycle_start_strobe_n;
  endsequence
  a_done_two_later: assert property (s_start |-> ##2 !cycle_done_n)
    else $error("no done two clocks after start");
  a_done_has_start: assert property (!cycle_done_n |-> $past(cycle_start_strobe_n, 2) == 1'b0)
    else $error("done without start");
  a_lanes_used: assert property (s_start |-> lane_select_n != 8'hff)
    else $error("no lane selected");
  a_lane_shape: assert property (s_start |-> $countones(~lane_select_n) inside {1, 2, 4, 8})
    else $error("odd lane count");
  a_depth_limit: assert property (open_cnt <= 3'h3)
    else $error("too many open transfers");
  a_hold_between: assert property (cycle_start_strobe_n |-> $stable(addr) && $stable(write_not_read))
    else $error("cycle controls moved");
  a_pair_step: assert property (s_pair |-> addr == $past(addr) + 29'h1)
    else $error("second word address wrong");
  a_pair_ends: assert property (s_pair |=> cycle_start_strobe_n)
    else $error("third back to back start");
endmodule
`default_nettype wire

// File: bench/lbal_bench.sv
`timescale 1ns/10ps
`default_nettype none
module lbal_bench;
  import lbal_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic rq_v = 1'b0, rq_w = 1'b0, rq_f = 1'b0, rq_s = 1'b0, sup = 1'b0, set_b = 1'b0;
  logic bval = 1'b0, rs_r = 1'b1, io = 1'b0, be = 1'b0, rdy, big, trap, rv, ioh, mb;
  logic [1:0] outs;
  lbal_size_t rq_sz = 3'h0;
  logic [31:0] rq_a = 32'h0;
  logic [127:0] rq_d = 128'h0;
  logic [63:0] rd;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  lbal_if lbal_if_i ();
  lbal_dev_end lbal_dev_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lbal_if_i.dev),
    .i_req_valid(rq_v), .o_req_ready(rdy), .i_req_write(rq_w), .i_req_fetch(rq_f),
    .i_req_signed(rq_s), .i_req_size(rq_sz), .i_req_addr(rq_a), .i_req_wdata(rq_d),
    .i_supervisor(sup), .i_set_big(set_b), .i_big_value(bval), .o_big_endian(big),
    .o_trap(trap), .o_rsp_valid(rv), .i_rsp_ready(rs_r), .o_rsp_data(rd), .o_outstanding(outs));
  lbal_mem_end lbal_mem_end_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(lbal_if_i.mem),
    .i_io_space(io), .o_io_hit(ioh), .o_busy(mb));
  lbal_checker lbal_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .addr(lbal_if_i.addr),
    .lane_select_n(lbal_if_i.lane_select_n), .cycle_start_strobe_n(lbal_if_i.cycle_start_strobe_n),
    .write_not_read(lbal_if_i.write_not_read), .cycle_done_n(lbal_if_i.cycle_done_n));
  initial forever #50 i_clk = ~i_clk;
  // hang guard, well above the 140 or so cycles used
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // expected active lanes; big mode mirrors them
  function automatic logic [7:0] lanes(input lbal_size_t sz, input logic [2:0] a, input logic b);
    logic [7:0] m;
    m = sz == 3'h0 ? 8'h01 << a : sz == 3'h1 ? 8'h03 << a : sz == 3'h2 ? 8'h0f << a : 8'hff;
    if (b) begin
      m = {<<{m}};
    end
    return m;
  endfunction
  // fl = {fetch, signed, misaligned}
  task automatic xfer(input logic w, input lbal_size_t sz, input logic [31:0] a,
    input logic [127:0] d, input logic [2:0] fl, input logic [63:0] e);
    int n;
    n = 0;
    @(posedge i_clk);
    rq_v <= 1'b1;
    rq_w <= w;
    rq_sz <= sz;
    rq_a <= a;
    rq_d <= d;
    rq_f <= fl[2];
    rq_s <= fl[1];
    @(negedge i_clk);
    while (rdy !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    rq_v <= 1'b0;
    @(negedge i_clk);
    if (fl[0]) begin
      chk("trap", 64'h1, {63'h0, trap});
      repeat (3) begin
        chk("no start", 64'h1, {63'h0, lbal_if_i.cycle_start_strobe_n});
        @(negedge i_clk);
      end
    end else begin
      chk("start", 64'h0, {63'h0, lbal_if_i.cycle_start_strobe_n});
      chk("lanes", {56'h0, ~lanes(sz, a[2:0], be && !fl[2])}, {56'h0, lbal_if_i.lane_select_n});
      chk("addr", {35'h0, a[31:3]}, {35'h0, lbal_if_i.addr});
      chk("dir", {63'h0, w}, {63'h0, lbal_if_i.write_not_read});
      n = 0;
      while (!w && rs_r && rv !== 1'b1 && n < 10) begin
        @(negedge i_clk);
        n++;
      end
      if (!w && rs_r) chk("read", e, rd);
    end
  endtask
  task automatic set_mode(input logic s, input logic v);
    @(posedge i_clk);
    sup <= s;
    set_b <= 1'b1;
    bval <= v;
    @(posedge i_clk);
    set_b <= 1'b0;
    @(negedge i_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk("mode at reset", 64'h0, {63'h0, big});
    chk("idle start", 64'h1, {63'h0, lbal_if_i.cycle_start_strobe_n});
    // little-endian round trips, narrow writes merge into the word
    xfer(1'b1, 3'h3, 32'h40, 128'h8877665544332211, 3'h0, 64'h0);
    xfer(1'b1, 3'h0, 32'h41, 128'haa, 3'h0, 64'h0);
    xfer(1'b0, 3'h0, 32'h47, 128'h0, 3'h2, 64'hffffffffffffff88);
    xfer(1'b0, 3'h0, 32'h47, 128'h0, 3'h0, 64'h88);
    xfer(1'b0, 3'h1, 32'h46, 128'h0, 3'h2, 64'hffffffffffff8877);
    xfer(1'b0, 3'h2, 32'h44, 128'h0, 3'h0, 64'h88776655);
    xfer(1'b1, 3'h2, 32'h44, 128'h12345678, 3'h0, 64'h0);
    xfer(1'b1, 3'h1, 32'h42, 128'hbeef, 3'h0, 64'h0);
    xfer(1'b0, 3'h3, 32'h40, 128'h0, 3'h0, 64'h12345678beefaa11);
    xfer(1'b1, 3'h4, 32'h80, {64'h0123456789abcdef, 64'h5}, 3'h0, 64'h0);
    @(negedge i_clk);
    chk("two in flight", 64'h2, {62'h0, outs});
    xfer(1'b0, 3'h3, 32'h88, 128'h0, 3'h0, 64'h0123456789abcdef);
    chk("mem cache fill", 64'h0, {63'h0, lbal_if_i.cache_fill_enable_n});
    chk("mem hit", 64'h0, {63'h0, ioh});
    // same word again, now decoded as i/o: caching must be held off
    @(posedge i_clk);
    io <= 1'b1;
    xfer(1'b0, 3'h3, 32'h88, 128'h0, 3'h0, 64'h0123456789abcdef);
    chk("io hit", 64'h1, {63'h0, ioh});
    chk("io cache fill", 64'h1, {63'h0, lbal_if_i.cache_fill_enable_n});
    @(posedge i_clk);
    io <= 1'b0;
    $display("round trip test done");
    for (int k = 1; k < 5; k++) begin
      xfer(k[0], k[2:0], 32'h100 + (32'h1 << (k - 1)), 128'h0, 3'h1, 64'h0);
    end
    $display("misalign test done");
    set_mode(1'b0, 1'b1);
    chk("mode needs supervisor", 64'h0, {63'h0, big});
    set_mode(1'b1, 1'b1);
    chk("big mode", 64'h1, {63'h0, big});
    be = 1'b1;
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, 3'h0, 32'hc0 + i, 128'h5a, 3'h0, 64'h0);
    end
    xfer(1'b1, 3'h1, 32'hc2, 128'h0, 3'h0, 64'h0);
    xfer(1'b1, 3'h2, 32'hc4, 128'h0, 3'h0, 64'h0);
    xfer(1'b1, 3'h0, 32'hc3, 128'h5a, 3'h0, 64'h0);
    xfer(1'b0, 3'h0, 32'hc3, 128'h0, 3'h0, 64'h5a);
    xfer(1'b0, 3'h2, 32'h44, 128'h0, 3'h4, 64'h12345678);
    set_mode(1'b1, 1'b0);
    be = 1'b0;
    $display("endian test done");
    // consumer stalls: two results fill the buffer, a third read waits
    @(posedge i_clk);
    rs_r <= 1'b0;
    xfer(1'b0, 3'h3, 32'h40, 128'h0, 3'h0, 64'h0);
    xfer(1'b0, 3'h3, 32'h88, 128'h0, 3'h0, 64'h0);
    repeat (6) @(posedge i_clk);
    rq_v <= 1'b1;
    repeat (6) begin
      @(negedge i_clk);
      chk("full refuses", 64'h0, {63'h0, rdy});
    end
    @(posedge i_clk);
    rq_v <= 1'b0;
    rs_r <= 1'b1;
    @(negedge i_clk);
    chk("first held", 64'h12345678beefaa11, rd);
    @(negedge i_clk);
    chk("second held", 64'h0123456789abcdef, rd);
    @(negedge i_clk);
    chk("drained", 64'h0, {63'h0, rv});
    chk("none open", 64'h0, {62'h0, outs});
    chk("mem idle", 64'h0, {63'h0, mb});
    $display("buffer test done");
    conclude();
  end
endmodule
`default_nettype wire
